// *** core/smc_config_loader.sv ***
// Strap mode configuration loader with APB register file and link mode control
`timescale 1ns/1ps
`default_nettype none
module smc_config_loader
	import smc_pkg::*;
(
	input wire logic clk_sys, // System clock, 20 MHz
	input wire logic sys_rst, // Asynchronous reset, active high
	input wire logic [smc_pkg::SMC_LEVEL_W-1:0] strap_level_in_a, // Strap A level index
	input wire logic [smc_pkg::SMC_LEVEL_W-1:0] strap_level_in_b, // Strap B level index
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [smc_pkg::SMC_DATA_W-1:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB byte strobes
	output logic [smc_pkg::SMC_DATA_W-1:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic remote_id_found, // Remote display-ID present
	input wire logic secondary_rx_capable, // Receiver supports control on secondary
	input wire logic legacy_receiver, // Legacy-generation receiver attached
	input wire logic [7:0] pixel_rate_mhz, // Measured pixel rate in MHz
	output logic use_remote_display_id, // Read display-ID from remote
	output logic use_local_display_id, // Use external local display-ID
	output logic [7:0] remote_id_bus_addr, // Bus address of remote ID
	output logic copy_remote_to_memory, // Copy remote ID into internal memory
	output logic aux_audio_enable, // Carry auxiliary audio channel
	output logic external_input_control, // Input controlled over serial pins
	output logic cable_type_bit, // Link configured for cable_type_select
	output logic secondary_phy_enable, // Secondary transmit PHY on
	output logic secondary_back_channel_enable, // Secondary back channel on
	output logic secondary_control_active, // Secondary link carries control
	output logic rate_within_limit, // Pixel rate within single-link limit
	output logic config_loaded // Strap values latched
);
	smc_state_t state;
	logic [SMC_LEVEL_W-1:0] sync_a;
	logic [SMC_LEVEL_W-1:0] sync_b;
	logic dec_src;
	logic dec_aux;
	logic dec_ext;
	logic dec_cable;
	logic dec_load;
	logic [7:0] edid_bridge_control;
	logic [7:0] bridge_config;
	logic [7:0] link_mode_control;
	logic [7:0] remote_id_addr;
	logic [7:0] link_status;
	logic [7:0] index;
	logic index_ok;
	logic aligned;
	logic mapped;
	logic wr_en;
	logic rd_en;
	logic latch_now;
	logic sync_full;
	logic [7:0] next_rdata;

	smc_sync2 #(.WIDTH(2 * SMC_LEVEL_W)) u_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.d({strap_level_in_a, strap_level_in_b}),
		.q({sync_a, sync_b})
	);

	smc_strap_decode u_decode (
		.level_a(sync_a),
		.level_b(sync_b),
		.display_id_source_select(dec_src),
		.aux_audio_select(dec_aux),
		.external_controller_override(dec_ext),
		.cable_type_select(dec_cable),
		.remote_display_id_load(dec_load)
	);

	// Synchroniser is cleared by reset; it holds strap levels two edges after release
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sync_full <= 1'b0;
		end else begin
			sync_full <= 1'b1;
		end
	end

	// Sequencer waits for the synchroniser to fill, then latches once
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state <= SMC_ST_SYNC;
		end else begin
			case (state)
				SMC_ST_SYNC: begin
					if (sync_full) begin
						state <= SMC_ST_LATCH;
					end
				end
				SMC_ST_LATCH: begin
					state <= SMC_ST_DONE;
				end
				SMC_ST_DONE: begin
					state <= SMC_ST_DONE;
				end
				default: begin
					state <= SMC_ST_SYNC;
				end
			endcase
		end
	end
	assign latch_now = (state == SMC_ST_LATCH);
	assign config_loaded = (state == SMC_ST_DONE);

	// APB decode: index is byte address divided by four
	assign index = paddr[9:2];
	assign aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
	always_comb begin
		case (index)
			SMC_IDX_EDID_BRIDGE_CONTROL,
			SMC_IDX_BRIDGE_CONFIG,
			SMC_IDX_LINK_MODE_CONTROL,
			SMC_IDX_REMOTE_ID_ADDR,
			SMC_IDX_LINK_STATUS: begin
				index_ok = 1'b1;
			end
			default: begin
				index_ok = 1'b0;
			end
		endcase
	end
	assign mapped = aligned && index_ok;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign wr_en = psel && penable && pwrite && mapped && pstrb[0];
	assign rd_en = psel && penable && !pwrite;

	// Writes to the three strap-loaded registers are blocked while the latch runs; the strap copy wins there
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			edid_bridge_control <= SMC_REG_RESET;
		end else if (latch_now) begin
			edid_bridge_control[SMC_BIT_DISPLAY_ID_SOURCE] <= dec_src;
		end else if (wr_en && index == SMC_IDX_EDID_BRIDGE_CONTROL) begin
			edid_bridge_control <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			bridge_config <= SMC_REG_RESET;
		end else if (latch_now) begin
			bridge_config[SMC_BIT_AUX_AUDIO] <= dec_aux;
			bridge_config[SMC_BIT_REMOTE_LOAD] <= dec_load;
			bridge_config[SMC_BIT_EXTERNAL_OVERRIDE] <= dec_ext;
		end else if (wr_en && index == SMC_IDX_BRIDGE_CONFIG) begin
			bridge_config <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			link_mode_control <= SMC_REG_RESET;
		end else if (latch_now) begin
			link_mode_control[SMC_BIT_CABLE_TYPE] <= dec_cable;
		end else if (wr_en && index == SMC_IDX_LINK_MODE_CONTROL) begin
			link_mode_control <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			remote_id_addr <= SMC_REMOTE_ID_ADDR_DEFAULT;
		end else if (wr_en && index == SMC_IDX_REMOTE_ID_ADDR) begin
			remote_id_addr <= pwdata[7:0];
		end
	end

	// Read-only snapshot of the link state
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			link_status <= SMC_REG_RESET;
		end else begin
			link_status <= {4'h0, legacy_receiver, secondary_rx_capable, rate_within_limit,
				config_loaded};
		end
	end

	always_comb begin
		case (index)
			SMC_IDX_EDID_BRIDGE_CONTROL: next_rdata = edid_bridge_control;
			SMC_IDX_BRIDGE_CONFIG: next_rdata = bridge_config;
			SMC_IDX_LINK_MODE_CONTROL: next_rdata = link_mode_control;
			SMC_IDX_REMOTE_ID_ADDR: next_rdata = remote_id_addr;
			SMC_IDX_LINK_STATUS: next_rdata = link_status;
			default: next_rdata = 8'h00;
		endcase
		if (!aligned) begin
			next_rdata = 8'h00;
		end
	end
	// Read data registered at setup so it is stable through the access phase
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			prdata <= {24'h000000, next_rdata};
		end
	end

	// Option outputs follow the register values; use_remote_display_id and copy_remote_to_memory also need remote_id_found
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			use_remote_display_id <= 1'b0;
			use_local_display_id <= 1'b0;
			copy_remote_to_memory <= 1'b0;
			remote_id_bus_addr <= SMC_REMOTE_ID_ADDR_DEFAULT;
		end else begin
			use_local_display_id <= edid_bridge_control[SMC_BIT_DISPLAY_ID_SOURCE];
			use_remote_display_id <= !edid_bridge_control[SMC_BIT_DISPLAY_ID_SOURCE]
				&& remote_id_found;
			copy_remote_to_memory <= bridge_config[SMC_BIT_REMOTE_LOAD]
				&& remote_id_found;
			remote_id_bus_addr <= remote_id_addr;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			aux_audio_enable <= 1'b0;
			external_input_control <= 1'b0;
			cable_type_bit <= 1'b0;
		end else begin
			aux_audio_enable <= bridge_config[SMC_BIT_AUX_AUDIO];
			external_input_control <= bridge_config[SMC_BIT_EXTERNAL_OVERRIDE];
			cable_type_bit <= link_mode_control[SMC_BIT_CABLE_TYPE];
		end
	end

	// Secondary link: control only when capable and not forced single
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			secondary_phy_enable <= 1'b0;
			secondary_back_channel_enable <= 1'b0;
			secondary_control_active <= 1'b0;
			rate_within_limit <= 1'b0;
		end else begin
			secondary_phy_enable <= !link_mode_control[SMC_BIT_FORCED_SINGLE];
			secondary_back_channel_enable <= !link_mode_control[SMC_BIT_FORCED_SINGLE];
			secondary_control_active <= !link_mode_control[SMC_BIT_FORCED_SINGLE]
				&& link_mode_control[SMC_BIT_SEC_CONTROL_EN] && secondary_rx_capable;
			// Legacy partner keeps the rate under its lower limit
			rate_within_limit <= legacy_receiver ? (pixel_rate_mhz < SMC_RATE_MAX_LEGACY_MHZ)
				: (pixel_rate_mhz <= SMC_RATE_MAX_NEW_MHZ);
		end
	end

	latch_once_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == SMC_ST_DONE) |=> (state == SMC_ST_DONE))
		else $error("strap latch state left done");
	latch_src_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		latch_now |=> edid_bridge_control[SMC_BIT_DISPLAY_ID_SOURCE] == $past(dec_src))
		else $error("source select not latched");
	latch_cfg_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		latch_now |=> bridge_config[SMC_BIT_EXTERNAL_OVERRIDE] == $past(dec_ext)
		&& bridge_config[SMC_BIT_REMOTE_LOAD] == $past(dec_load))
		else $error("bridge config not latched");
	latch_cable_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		latch_now |=> link_mode_control[SMC_BIT_CABLE_TYPE] == $past(dec_cable))
		else $error("cable type not latched");
	sw_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(wr_en && !latch_now && index == SMC_IDX_BRIDGE_CONFIG)
		|=> bridge_config == $past(pwdata[7:0]))
		else $error("software write lost");
	forced_single_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		link_mode_control[SMC_BIT_FORCED_SINGLE]
		|=> !secondary_phy_enable && !secondary_control_active)
		else $error("secondary phy on in forced single");
	back_channel_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		link_mode_control[SMC_BIT_FORCED_SINGLE] |=> !secondary_back_channel_enable)
		else $error("back channel on in forced single");
	latch_aux_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		latch_now |=> bridge_config[SMC_BIT_AUX_AUDIO] == $past(dec_aux))
		else $error("aux audio not latched");
	legacy_rate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(legacy_receiver && pixel_rate_mhz >= SMC_RATE_MAX_LEGACY_MHZ)
		|=> !rate_within_limit)
		else $error("legacy rate limit not applied");
	addr_follow_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		1'b1 |=> remote_id_bus_addr == $past(remote_id_addr))
		else $error("remote address not applied");
	cable_type_select_follow_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$rose(link_mode_control[SMC_BIT_CABLE_TYPE]) |=> cable_type_bit)
		else $error("cable_type_bit not applied");
	local_id_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		use_local_display_id |-> !use_remote_display_id)
		else $error("local and remote display-ID both used");
	load_done_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$fell(sys_rst) |-> ##3 config_loaded)
		else $error("straps not loaded in time");
endmodule // smc_config_loader
`default_nettype wire

// *** core/smc_strap_decode.sv ***
// Decoder from the two strap level indices to the five option bits
`timescale 1ns/1ps
`default_nettype none
module smc_strap_decode
	import smc_pkg::*;
(
	input wire logic [smc_pkg::SMC_LEVEL_W-1:0] level_a, // Strap A level index 0..3
	input wire logic [smc_pkg::SMC_LEVEL_W-1:0] level_b, // Strap B level index 0..7
	output logic display_id_source_select, // Decoded display-ID source
	output logic aux_audio_select, // Decoded auxiliary audio
	output logic external_controller_override, // Decoded external override
	output logic cable_type_select, // Decoded cable type
	output logic remote_display_id_load // Decoded remote load
);
	logic [1:0] pair_a;
	always_comb begin
		// Levels above the top step do not occur; clamp keeps the decode defined
		pair_a = (level_a > SMC_LEVEL_A_MAX) ? SMC_LEVEL_A_MAX[1:0] : level_a[1:0];
	end
	assign display_id_source_select = pair_a[1];
	assign aux_audio_select = pair_a[0];
	assign external_controller_override = level_b[2];
	assign cable_type_select = level_b[1];
	assign remote_display_id_load = level_b[0];
endmodule // smc_strap_decode
`default_nettype wire

// *** core/smc_sync2.sv ***
// Two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
`default_nettype none
module smc_sync2 #(
	parameter int WIDTH = 3
) (
	input wire logic clk_sys, // System clock
	input wire logic sys_rst, // Asynchronous reset, active high
	input wire logic [WIDTH-1:0] d, // Asynchronous input
	output logic [WIDTH-1:0] q // Synchronised output
);
	logic [WIDTH-1:0] meta;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // smc_sync2
`default_nettype wire

// *** include/smc_pkg.sv ***
// Package for the strap mode configuration loader: register map, fields, constants
package smc_pkg;
	localparam int SMC_ADDR_W = 8;
	localparam int SMC_DATA_W = 32;
	localparam int SMC_REG_W = 8;
	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] SMC_IDX_EDID_BRIDGE_CONTROL = 8'h4F;
	localparam logic [7:0] SMC_IDX_BRIDGE_CONFIG = 8'h54;
	localparam logic [7:0] SMC_IDX_LINK_MODE_CONTROL = 8'h5B;
	localparam logic [7:0] SMC_IDX_REMOTE_ID_ADDR = 8'h60;
	localparam logic [7:0] SMC_IDX_LINK_STATUS = 8'h61;
	localparam logic [9:0] SMC_BYTE_SCALE = 10'h004;
	// Field positions
	localparam int SMC_BIT_DISPLAY_ID_SOURCE = 0;
	localparam int SMC_BIT_AUX_AUDIO = 1;
	localparam int SMC_BIT_REMOTE_LOAD = 5;
	localparam int SMC_BIT_EXTERNAL_OVERRIDE = 7;
	localparam int SMC_BIT_CABLE_TYPE = 7;
	localparam int SMC_BIT_FORCED_SINGLE = 0;
	localparam int SMC_BIT_SEC_CONTROL_EN = 1;
	// Reset values and defaults
	localparam logic [7:0] SMC_REG_RESET = 8'h00;
	localparam logic [7:0] SMC_REMOTE_ID_ADDR_DEFAULT = 8'hA0;
	// Strap level indices
	localparam int SMC_LEVEL_W = 3;
	localparam logic [2:0] SMC_LEVEL_A_MAX = 3'h3;
	// Pixel rate limits in MHz
	localparam logic [7:0] SMC_RATE_MAX_NEW_MHZ = 8'h60;
	localparam logic [7:0] SMC_RATE_MAX_LEGACY_MHZ = 8'h55;
	typedef enum logic [1:0] {SMC_ST_SYNC, SMC_ST_LATCH, SMC_ST_DONE} smc_state_t;
endpackage

// *** verification/smc_far_side.sv ***
// Far-side model: board strap dividers and the downstream receiver
`timescale 1ns/1ps
`default_nettype none
module smc_far_side (
	input wire logic [1:0] pick_a, // Chosen strap A divider
	input wire logic [2:0] pick_b, // Chosen strap B divider
	input wire logic found, // Remote display-ID present
	input wire logic capable, // Receiver takes control on secondary link
	input wire logic legacy, // Legacy receiver attached
	input wire logic [7:0] rate, // Requested pixel rate in MHz
	output logic [2:0] strap_level_in_a, // Strap A level index
	output logic [2:0] strap_level_in_b, // Strap B level index
	output logic remote_id_found, // Remote ID seen by the receiver
	output logic secondary_rx_capable, // Receiver capability
	output logic legacy_receiver, // Receiver generation
	output logic [7:0] pixel_rate_mhz // Pixel rate offered by the source
);
	// Dividers only ever present defined levels
	assign strap_level_in_a = {1'b0, pick_a};
	assign strap_level_in_b = pick_b;
	assign remote_id_found = found;
	assign secondary_rx_capable = capable;
	assign legacy_receiver = legacy;
	// A source feeding a legacy receiver stays below its limit
	assign pixel_rate_mhz = (legacy && rate > 8'h54) ? 8'h54 : rate;
endmodule // smc_far_side
`default_nettype wire

// *** verification/tb_strap_mode_config_loader.sv ***
// Testbench for the strap mode configuration loader
`timescale 1ns/1ps
`default_nettype none
module tb_strap_mode_config_loader;
	logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic [3:0] pstrb;
	logic [2:0] strap_level_in_a, strap_level_in_b, pick_b;
	logic [1:0] pick_a;
	logic found, capable, legacy, remote_id_found, secondary_rx_capable, legacy_receiver;
	logic [7:0] rate, pixel_rate_mhz, remote_id_bus_addr;
	logic use_remote_display_id, use_local_display_id, copy_remote_to_memory;
	logic aux_audio_enable, external_input_control, cable_type_bit, secondary_phy_enable;
	logic secondary_back_channel_enable, secondary_control_active, rate_within_limit;
	logic config_loaded;
	logic [32:0] expq[$];
	int miscompares, n_tests;

	smc_config_loader DUT (.clk_sys, .sys_rst, .strap_level_in_a, .strap_level_in_b,
		.psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.remote_id_found, .secondary_rx_capable, .legacy_receiver, .pixel_rate_mhz,
		.use_remote_display_id, .use_local_display_id, .remote_id_bus_addr,
		.copy_remote_to_memory, .aux_audio_enable, .external_input_control, .cable_type_bit,
		.secondary_phy_enable, .secondary_back_channel_enable, .secondary_control_active,
		.rate_within_limit, .config_loaded);
	smc_far_side far (.pick_a, .pick_b, .found, .capable, .legacy, .rate,
		.strap_level_in_a, .strap_level_in_b, .remote_id_found, .secondary_rx_capable,
		.legacy_receiver, .pixel_rate_mhz);

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic checkb(input logic seen, input logic exp);
		check({32'h0, seen}, {32'h0, exp});
	endtask

	task automatic end_of_test;
		$display("Mismatches %0d, comparisons %0d", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask

	// One APB transfer; a read notes its expected {pslverr, prdata}
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		input logic [32:0] e);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		if (!w) expq.push_back(e);
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			miscompares++;
			end_of_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic do_reset;
		int n;
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		n = 0;
		while (config_loaded !== 1'b1 && n < 10) begin
			@(posedge clk_sys);
			n++;
		end
		if (config_loaded !== 1'b1) begin
			miscompares++;
			end_of_test();
		end
		wt(2);
	endtask

	// Read results are taken off the queue at the completing edge
	always @(posedge clk_sys) begin
		if (psel && penable && pready && !pwrite) begin
			if (expq.size() == 0) begin
				check({pslverr, prdata}, 33'h1FFFFFFFF);
			end else begin
				check({pslverr, prdata}, expq.pop_front());
			end
		end
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		miscompares++;
		end_of_test();
	end

	initial begin
		sys_rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hF;
		{pick_a, pick_b, capable, legacy} = '0;
		found = 1'b1;
		rate = 8'h40;
		miscompares = 0;
		n_tests = 0;
		void'($urandom(32'h41f8b523));
		for (int i = 0; i < 8; i++) begin
			pick_a <= i[1:0];
			pick_b <= i[2:0];
			do_reset();
			apb(1'b0, 12'h13C, 32'h0, {32'h0, pick_a[1]});
			apb(1'b0, 12'h150, 32'h0,
				{25'h0, pick_b[2], 1'b0, pick_b[0], 3'h0, pick_a[0], 1'b0});
			apb(1'b0, 12'h16C, 32'h0, {25'h0, pick_b[1], 7'h0});
			wt(1);
			checkb(cable_type_bit, pick_b[1]);
			checkb(external_input_control, pick_b[2]);
			checkb(aux_audio_enable, pick_a[0]);
			checkb(use_local_display_id, pick_a[1]);
			checkb(use_remote_display_id, !pick_a[1]);
			checkb(copy_remote_to_memory, pick_b[0]);
			check({25'h0, remote_id_bus_addr}, {25'h0, 8'hA0});
		end
		pick_a <= 2'h0;
		pick_b <= 3'h0;
		wt(5);
		apb(1'b0, 12'h150, 32'h0, {25'h0, 8'hA2});
		d = $urandom;
		apb(1'b1, 12'h150, d, 33'h0);
		apb(1'b0, 12'h150, 32'h0, {25'h0, d[7:0]});
		wt(2);
		checkb(aux_audio_enable, d[1]);
		checkb(external_input_control, d[7]);
		apb(1'b0, 12'h180, 32'h0, {25'h0, 8'hA0});
		d = $urandom;
		apb(1'b1, 12'h180, d, 33'h0);
		wt(2);
		check({25'h0, remote_id_bus_addr}, {25'h0, d[7:0]});
		apb(1'b1, 12'h13C, 32'h0, 33'h0);
		apb(1'b1, 12'h150, 32'h20, 33'h0);
		wt(2);
		checkb(use_remote_display_id, 1'b1);
		checkb(copy_remote_to_memory, 1'b1);
		found <= 1'b0;
		wt(2);
		checkb(use_remote_display_id, 1'b0);
		checkb(copy_remote_to_memory, 1'b0);
		capable <= 1'b1;
		apb(1'b1, 12'h16C, 32'h03, 33'h0);
		wt(2);
		checkb(secondary_phy_enable, 1'b0);
		checkb(secondary_back_channel_enable, 1'b0);
		checkb(secondary_control_active, 1'b0);
		apb(1'b1, 12'h16C, 32'h02, 33'h0);
		wt(2);
		checkb(secondary_phy_enable, 1'b1);
		checkb(secondary_control_active, 1'b1);
		checkb(cable_type_bit, 1'b0);
		capable <= 1'b0;
		wt(2);
		checkb(secondary_control_active, 1'b0);
		rate <= 8'h60;
		wt(2);
		checkb(rate_within_limit, 1'b1);
		rate <= 8'h61;
		wt(2);
		checkb(rate_within_limit, 1'b0);
		legacy <= 1'b1;
		wt(2);
		checkb(rate_within_limit, 1'b1);
		apb(1'b0, 12'h200, 32'h0, {1'b1, 32'h0});
		apb(1'b0, 12'h13D, 32'h0, {1'b1, 32'h0});
		wt(2);
		end_of_test();
	end
endmodule // tb_strap_mode_config_loader
`default_nettype wire
